/* File: design/usb_hc_params.svh */
// Register map, field positions and timing constants of the operating control block
`ifndef USB_HC_PARAMS_SVH
`define USB_HC_PARAMS_SVH

// ****************************************************************
// Register indexes and byte addresses
// ****************************************************************
// Operating control register, read index and write index
`define HOC_READ_IDX 10'h001
`define HOC_WRITE_IDX 10'h081
// Event status, event mask and command words, byte addresses
`define EVT_STATUS_ADDR 12'h300
`define EVT_MASK_ADDR 12'h304
`define HC_CMD_ADDR 12'h308

// ****************************************************************
// Field positions
// ****************************************************************
`define HOC_RWE_BIT 10
`define HOC_RWC_BIT 9
`define HOC_FS_LSB 6
`define HOC_FS_MSB 7
// Event flag layout, shared by status and mask
`define EVT_WIDTH 2
`define EVT_FRAME_START_BIT 0
`define EVT_RESUME_SEEN_BIT 1
// Command word: write bit, read-back state bits
`define CMD_SW_RESET_BIT 0
`define CMD_SOF_ACTIVE_BIT 1
`define CMD_DS_RESET_BIT 2

// ****************************************************************
// Reset values
// ****************************************************************
`define WORD_ZERO 32'h0000_0000
`define EVT_ZERO 2'h0

// ****************************************************************
// Timing
// ****************************************************************
// Frame start delay after entering operational, in ns
`define SOF_DELAY_NS 1000000
`define CLK_PERIOD_NS 4
// Length of downstream reset signaling after a hardware reset
`define DS_RESET_CYCLES_DEFAULT 16

`endif

/* File: design/usb_hc_pkg.sv */
// Types shared by the operating control block
package usb_hc_pkg;

    // Functional state encoding, fixed by the register layout
    typedef enum logic [1:0] {
        hc_state_reset = 2'h0,
        hc_state_resume = 2'h1,
        hc_state_operational = 2'h2,
        hc_state_suspend = 2'h3
    } functional_state_t;

endpackage

/* File: design/sof_start_timer.sv */
// Delay timer that starts frame generation a fixed time after entering operational
`timescale 1ns/1ps
`include "usb_hc_params.svh"

module sof_start_timer #(
    parameter int DELAY_CYCLES = `SOF_DELAY_NS / `CLK_PERIOD_NS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic run,
    output logic sof_active_ff,
    output logic frame_start_ff
);

    // ****************************************************************
    // Parameter check
    // ****************************************************************
    localparam int CW = $clog2(DELAY_CYCLES + 1);

    if (DELAY_CYCLES < 1) begin : g_bad_delay
        $error("DELAY_CYCLES must be at least one");
    end

    // ****************************************************************
    // Countdown
    // ****************************************************************
    logic [CW-1:0] cnt_ff; // Cycles left before frames start
    logic counting_ff; // Waiting for the delay to pass
    wire cnt_done = counting_ff && (cnt_ff == CW'(1));

    // load on entry, count while operational
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= '0;
            counting_ff <= 1'b0;
            sof_active_ff <= 1'b0;
            frame_start_ff <= 1'b0;
        end else begin
            frame_start_ff <= run && cnt_done;
            if (!run) begin
                // Leaving operational stops everything
                counting_ff <= 1'b0;
                sof_active_ff <= 1'b0;
            end else if (start) begin
                cnt_ff <= CW'(DELAY_CYCLES);
                counting_ff <= 1'b1;
                sof_active_ff <= 1'b0;
            end else if (cnt_done) begin
                counting_ff <= 1'b0;
                sof_active_ff <= 1'b1;
            end else if (counting_ff) begin
                cnt_ff <= cnt_ff - CW'(1);
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    int elapsed_ff; // Helper: cycles since the last start

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            elapsed_ff <= 0;
        end else if (start) begin
            elapsed_ff <= 1;
        end else begin
            elapsed_ff <= elapsed_ff + 1;
        end
    end

    a_sof_start_delay: assert property (
        @(posedge clk) disable iff (rst)
        $rose(sof_active_ff) |-> (elapsed_ff == DELAY_CYCLES + 1) && $past(run))
    else $error("frame generation did not start exactly one delay after entry");

endmodule

/* File: design/usb_host_operating_control.sv */
// Operating control register bank with APB slave, state control and event interrupt
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "usb_hc_params.svh"

// Functional notes
// - Wake enable plus resume flag signals wake
// - Wake enable never gates the interrupt
// - Connected bit: hardware reset clears, software keeps
// - State codes 00/01/10/11; hardware changes only suspended
// - Frames start one millisecond after entering operational
// - Suspend moves to resume on downstream resume
// - Any reset puts state to reset
// - Hardware reset resets hub, then downstream reset
// - Read at index 01, write at 81
module usb_host_operating_control #(
    parameter int SOF_DELAY_CYCLES = `SOF_DELAY_NS / `CLK_PERIOD_NS,
    parameter int DS_RESET_CYCLES = `DS_RESET_CYCLES_DEFAULT
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic downstream_resume,
    output logic irq,
    output logic remote_wake,
    output logic sof_active,
    output logic root_hub_reset,
    output logic downstream_reset
);

    // ****************************************************************
    // Parameter check and helpers
    // ****************************************************************
    localparam int DW = $clog2(DS_RESET_CYCLES + 1);

    if (DS_RESET_CYCLES < 1) begin : g_bad_ds
        $error("DS_RESET_CYCLES must be at least one");
    end

    // Byte address of a register index
    function automatic logic [11:0] idx_addr(input logic [9:0] idx);
        idx_addr = {idx, 2'h0};
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    usb_hc_pkg::functional_state_t fs_ff; // Functional state field
    usb_hc_pkg::functional_state_t nxt_fs;
    usb_hc_pkg::functional_state_t fs_prev_ff; // Last cycle state, for entry detect
    logic rwe_ff; // Remote wake enable
    logic rwc_ff; // Remote wake connected
    logic [`EVT_WIDTH-1:0] status_ff; // Sticky event flags
    logic [`EVT_WIDTH-1:0] nxt_status;
    logic [`EVT_WIDTH-1:0] mask_ff; // Interrupt mask, one enables
    logic [31:0] prdata_ff; // Read data
    logic pready_ff; // Access complete
    logic pslverr_ff; // Access error
    logic irq_ff; // Interrupt line
    logic remote_wake_ff; // Wake toward host system
    logic root_hub_reset_ff; // Hub held in reset
    logic downstream_reset_ff; // Reset signaling on ports
    logic [DW-1:0] ds_cnt_ff; // Cycles of port reset left
    logic sw_reset_ff; // Software reset in progress
    logic sof_run_ff; // Frames generated
    logic frame_start_pulse; // First frame sent

    // ****************************************************************
    // APB decode
    // ****************************************************************
    wire access = psel && penable && !pready_ff;
    wire commit = psel && penable && pready_ff;
    wire hit_ctrl_rd = paddr == idx_addr(`HOC_READ_IDX);
    wire hit_ctrl_wr = paddr == idx_addr(`HOC_WRITE_IDX);
    wire hit_status = paddr == `EVT_STATUS_ADDR;
    wire hit_mask = paddr == `EVT_MASK_ADDR;
    wire hit_cmd = paddr == `HC_CMD_ADDR;
    // read index readable only, write index writable only
    wire legal = pwrite ? (hit_ctrl_wr || hit_status || hit_mask || hit_cmd)
                        : (hit_ctrl_rd || hit_status || hit_mask || hit_cmd);
    wire wr_ok = commit && pwrite && legal;
    wire ctrl_wr = wr_ok && hit_ctrl_wr;
    wire status_wr = wr_ok && hit_status;
    wire mask_wr = wr_ok && hit_mask;
    wire sw_reset_req = wr_ok && hit_cmd && pwdata[`CMD_SW_RESET_BIT];

    wire [31:0] ctrl_word = (32'(rwe_ff) << `HOC_RWE_BIT)
                          | (32'(rwc_ff) << `HOC_RWC_BIT)
                          | (32'(fs_ff) << `HOC_FS_LSB);
    wire [31:0] cmd_word = (32'(sof_run_ff) << `CMD_SOF_ACTIVE_BIT)
                         | (32'(downstream_reset_ff) << `CMD_DS_RESET_BIT);
    wire [31:0] rd_word = hit_ctrl_rd ? ctrl_word
                        : hit_status ? 32'(status_ff)
                        : hit_mask ? 32'(mask_ff)
                        : hit_cmd ? cmd_word
                        : `WORD_ZERO;

    // ****************************************************************
    // State and event next values
    // ****************************************************************
    wire fs_suspended = fs_ff == usb_hc_pkg::hc_state_suspend;
    wire resume_hit = fs_suspended && downstream_resume;
    wire enter_op = (fs_ff == usb_hc_pkg::hc_state_operational)
                 && (fs_prev_ff != usb_hc_pkg::hc_state_operational);
    wire [`EVT_WIDTH-1:0] evt_set = (`EVT_WIDTH'(frame_start_pulse) << `EVT_FRAME_START_BIT)
                                  | (`EVT_WIDTH'(resume_hit) << `EVT_RESUME_SEEN_BIT);
    wire [`EVT_WIDTH-1:0] evt_clr = status_wr ? pwdata[`EVT_WIDTH-1:0] : `EVT_ZERO;

    // Functional state: software write, else hardware resume
    always_comb begin
        nxt_fs = fs_ff;
        if (sw_reset_req) begin
            nxt_fs = usb_hc_pkg::hc_state_reset;
        end else if (ctrl_wr) begin
            nxt_fs = usb_hc_pkg::functional_state_t'(pwdata[`HOC_FS_MSB:`HOC_FS_LSB]);
        end else if (resume_hit) begin
            // hardware changes field only from suspend
            nxt_fs = usb_hc_pkg::hc_state_resume;
        end
    end

    // Sticky flags: set wins over a clear in the same cycle
    always_comb begin
        nxt_status = (status_ff & ~evt_clr) | evt_set;
    end

    // ****************************************************************
    // APB response registers
    // ****************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= `WORD_ZERO;
        end else begin
            pready_ff <= access;
            pslverr_ff <= access && !legal;
            if (access) begin
                prdata_ff <= (!pwrite && legal) ? rd_word : `WORD_ZERO;
            end
        end
    end

    // ****************************************************************
    // Control register
    // ****************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fs_ff <= usb_hc_pkg::hc_state_reset;
            fs_prev_ff <= usb_hc_pkg::hc_state_reset;
            rwe_ff <= 1'b0;
            rwc_ff <= 1'b0;
        end else begin
            fs_ff <= nxt_fs;
            fs_prev_ff <= fs_ff;
            if (sw_reset_req) begin
                rwe_ff <= 1'b0;
            end else if (ctrl_wr) begin
                // wake enable changes only by driver write
                rwe_ff <= pwdata[`HOC_RWE_BIT];
                rwc_ff <= pwdata[`HOC_RWC_BIT];
            end
        end
    end

    // ****************************************************************
    // Events, mask, interrupt and wake
    // ****************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_ff <= `EVT_ZERO;
            mask_ff <= `EVT_ZERO;
            irq_ff <= 1'b0;
            remote_wake_ff <= 1'b0;
        end else begin
            status_ff <= sw_reset_req ? `EVT_ZERO : nxt_status;
            if (sw_reset_req) begin
                mask_ff <= `EVT_ZERO;
            end else if (mask_wr) begin
                mask_ff <= pwdata[`EVT_WIDTH-1:0];
            end
            // interrupt from flags and mask alone
            irq_ff <= |(status_ff & mask_ff);
            // wake when enabled and resume flag set
            remote_wake_ff <= rwe_ff && status_ff[`EVT_RESUME_SEEN_BIT];
        end
    end

    // ****************************************************************
    // Hardware reset sequence toward root hub and ports
    // ****************************************************************
    // hub reset under hardware reset, then port reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            root_hub_reset_ff <= 1'b1;
            downstream_reset_ff <= 1'b0;
            ds_cnt_ff <= DW'(DS_RESET_CYCLES);
        end else if (root_hub_reset_ff) begin
            root_hub_reset_ff <= 1'b0;
            downstream_reset_ff <= 1'b1;
        end else if (downstream_reset_ff) begin
            ds_cnt_ff <= ds_cnt_ff - DW'(1);
            downstream_reset_ff <= ds_cnt_ff != DW'(1);
        end
    end

    // Software reset marker, one cycle, used only by the checks
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sw_reset_ff <= 1'b0;
        end else begin
            sw_reset_ff <= sw_reset_req;
        end
    end

    // ****************************************************************
    // Frame start timer
    // ****************************************************************
    // delayed frame start after entering operational
    sof_start_timer #(
        .DELAY_CYCLES(SOF_DELAY_CYCLES)
    ) u_sof_timer (
        .clk(clk),
        .rst(rst),
        .start(enter_op),
        .run(fs_ff == usb_hc_pkg::hc_state_operational),
        .sof_active_ff(sof_run_ff),
        .frame_start_ff(frame_start_pulse)
    );

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;
    assign remote_wake = remote_wake_ff;
    assign sof_active = sof_run_ff;
    assign root_hub_reset = root_hub_reset_ff;
    assign downstream_reset = downstream_reset_ff;

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_wake_cause;
        rwe_ff && status_ff[`EVT_RESUME_SEEN_BIT];
    endsequence

    sequence s_resume_in_suspend;
        resume_hit && !ctrl_wr && !sw_reset_req;
    endsequence

    a_remote_wake_follows: assert property (
        @(posedge clk) disable iff (rst)
        s_wake_cause |=> remote_wake_ff)
    else $error("remote wake not raised for enabled resume");

    a_irq_ignores_wake: assert property (
        @(posedge clk) disable iff (rst)
        ##1 irq_ff == |($past(status_ff) & $past(mask_ff)))
    else $error("interrupt does not follow flags and mask");

    a_rwc_keeps_value: assert property (
        @(posedge clk) disable iff (rst)
        sw_reset_ff |-> rwc_ff == $past(rwc_ff) && fs_ff == usb_hc_pkg::hc_state_reset)
    else $error("software reset disturbed connected bit or state");

    a_fs_hw_change: assert property (
        @(posedge clk) disable iff (rst)
        (fs_ff != $past(fs_ff)) && !$past(ctrl_wr) && !$past(sw_reset_req)
        |-> $past(fs_ff) == usb_hc_pkg::hc_state_suspend)
    else $error("hardware changed state outside suspend");

    a_resume_on_detect: assert property (
        @(posedge clk) disable iff (rst)
        s_resume_in_suspend |=> fs_ff == usb_hc_pkg::hc_state_resume
            ##0 status_ff[`EVT_RESUME_SEEN_BIT])
    else $error("resume detect did not move state and set flag");

    a_hw_reset_order: assert property (
        @(posedge clk) disable iff (rst)
        $fell(root_hub_reset_ff) |-> downstream_reset_ff && !sw_reset_ff)
    else $error("port reset did not follow hub reset");

    a_sw_no_port_reset: assert property (
        @(posedge clk) disable iff (rst)
        sw_reset_req && !downstream_reset_ff |=> !downstream_reset_ff[*2])
    else $error("software reset raised port reset");

    a_ctrl_read_word: assert property (
        @(posedge clk) disable iff (rst)
        access && !pwrite && hit_ctrl_rd |=> pready_ff && !pslverr_ff
            && prdata_ff[`HOC_FS_MSB:`HOC_FS_LSB] == $past(fs_ff))
    else $error("control read at read index gave wrong answer");

    a_reserved_zero: assert property (
        @(posedge clk) disable iff (rst)
        $past(access && !pwrite && hit_ctrl_rd) |->
            (prdata_ff & ~((32'h1 << `HOC_RWE_BIT) | (32'h1 << `HOC_RWC_BIT)
            | (32'h3 << `HOC_FS_LSB))) == `WORD_ZERO)
    else $error("reserved control bits not zero");

endmodule

/* File: dv/tb_top.sv */
// Self-checking bench for the operating control register bank
`timescale 1ns/1ps

module tb_top;

    // ****************************************************************
    // Signals and design instance
    // ****************************************************************
    localparam int SOF_CYC = 20; // Shortened frame start delay
    localparam int DS_CYC = 4; // Shortened downstream reset length
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic downstream_resume = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic remote_wake;
    logic sof_active;
    logic root_hub_reset;
    logic downstream_reset;
    int n_mismatch = 0; // Failed comparisons
    int compares = 0; // All comparisons
    logic [31:0] q; // Last read data
    logic e; // Last error response

    usb_host_operating_control #(.SOF_DELAY_CYCLES(SOF_CYC), .DS_RESET_CYCLES(DS_CYC)) dut_u (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .downstream_resume(downstream_resume), .irq(irq),
        .remote_wake(remote_wake), .sof_active(sof_active),
        .root_hub_reset(root_hub_reset), .downstream_reset(downstream_reset)
    );

    // 250 MHz clock
    initial begin
        forever #2 clk = ~clk;
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    // Verdict and end of run
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // One comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: no bus answer", $time);
            close_out();
        end
    endtask

    // Accepted write
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        chk({31'h0, e}, 32'h0, "write error");
    endtask

    // Accepted read with expected data
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        chk({31'h0, e}, 32'h0, "read error");
        chk(q, exp, "read data");
    endtask

    // Let some edges pass, then sample settled outputs
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Hardware reset with hub and port reset sequence
    task automatic hw_reset();
        @(posedge clk);
        rst <= 1'b1;
        tick(12);
        chk({31'h0, root_hub_reset}, 32'h1, "hub reset during rst");
        // Release on a rising edge, like every other input
        @(posedge clk);
        rst <= 1'b0;
        tick(1);
        chk({30'h0, root_hub_reset, downstream_reset}, 32'h1, "port reset start");
        tick(DS_CYC - 1);
        chk({31'h0, downstream_reset}, 32'h1, "port reset held");
        tick(1);
        chk({31'h0, downstream_reset}, 32'h0, "port reset end");
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        // Reset values
        hw_reset();
        rd(12'h004, 32'h0000_0000);
        rd(12'h300, 32'h0000_0000);
        rd(12'h304, 32'h0000_0000);
        $display("test reset done");

        // Field codes, reserved bits, refused places
        wr(12'h204, 32'hffff_ffff);
        rd(12'h004, 32'h0000_06c0);
        for (int s = 0; s < 4; s++) begin
            wr(12'h204, 32'(s) << 6);
            rd(12'h004, 32'(s) << 6);
        end
        xfer(1'b1, 12'h004, 32'h0000_0080);
        chk({31'h0, e}, 32'h1, "write to read place");
        xfer(1'b0, 12'h204, 32'h0000_0000);
        chk({31'h0, e}, 32'h1, "read of write place");
        chk(q, 32'h0000_0000, "refused read data");
        xfer(1'b0, 12'h010, 32'h0000_0000);
        chk({31'h0, e}, 32'h1, "unmapped");
        chk(q, 32'h0000_0000, "unmapped read data");
        rd(12'h004, 32'h0000_00c0);
        $display("test fields done");

        // Frame start after entering operational
        wr(12'h304, 32'h0000_0001);
        wr(12'h204, {24'h0, usb_hc_pkg::hc_state_operational, 6'h0});
        // Frames run from the delay plus one edge after the write lands
        tick(SOF_CYC);
        chk({31'h0, sof_active}, 32'h0, "frames too early");
        tick(1);
        chk({31'h0, sof_active}, 32'h1, "frames started");
        tick(2);
        chk({31'h0, irq}, 32'h1, "frame irq");
        rd(12'h300, 32'h0000_0001);
        rd(12'h308, 32'h0000_0002);
        downstream_resume <= 1'b1;
        repeat (3) @(posedge clk);
        downstream_resume <= 1'b0;
        rd(12'h004, 32'h0000_0080);
        wr(12'h300, 32'h0000_0001);
        rd(12'h300, 32'h0000_0000);
        tick(2);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        wr(12'h204, 32'h0000_00c0);
        tick(2);
        chk({31'h0, sof_active}, 32'h0, "frames stop");
        $display("test frames done");

        // Remote wake from suspend
        wr(12'h304, 32'h0000_0000);
        wr(12'h204, 32'h0000_04c0);
        // One cycle of resume signaling while suspended
        downstream_resume <= 1'b1;
        @(posedge clk);
        downstream_resume <= 1'b0;
        tick(3);
        rd(12'h004, 32'h0000_0440);
        rd(12'h300, 32'h0000_0002);
        chk({31'h0, remote_wake}, 32'h1, "wake signaled");
        chk({31'h0, irq}, 32'h0, "wake enable no irq");
        wr(12'h304, 32'h0000_0002);
        tick(2);
        chk({31'h0, irq}, 32'h1, "resume irq");
        wr(12'h204, 32'h0000_0040);
        tick(2);
        chk({31'h0, remote_wake}, 32'h0, "wake off");
        $display("test wake done");

        // Software reset keeps connected bit, hardware reset clears it
        wr(12'h204, 32'h0000_0680);
        wr(12'h308, 32'h0000_0001);
        tick(2);
        rd(12'h004, 32'h0000_0200);
        rd(12'h304, 32'h0000_0000);
        rd(12'h300, 32'h0000_0000);
        chk({30'h0, root_hub_reset, downstream_reset}, 32'h0, "no port reset");
        chk({31'h0, irq}, 32'h0, "irq after soft reset");
        hw_reset();
        rd(12'h004, 32'h0000_0000);
        $display("test resets done");
        close_out();
    end

endmodule
